// ===== pkg/enc_map.vh
// register map, field positions, reset values and timing for the encoder block
`ifndef ENC_MAP_VH
`define ENC_MAP_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define REG_CTRL          8'h00
`define REG_COUNT         8'h04
`define REG_STATUS        8'h08
`define REG_ALIGN         8'h0C
`define REG_TRIG          8'h10

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define CTRL_SINGLE_CH    0
`define CTRL_SINGLE_EVAL  1
`define CTRL_OVF_LO       2
`define CTRL_OVF_HI       3
`define CTRL_REVERSE      4
`define CTRL_INIT_DONE    5
`define CTRL_INIT_ERR     6
`define CTRL_TRIG_MODE    7
`define CTRL_CMD_MODE     8
`define CTRL_TASK_LO      12
`define CTRL_TASK_HI      15
`define CTRL_RESET        16'h0000
`define CTRL_WMASK        16'hF1FF

// ----------------------------------------------------------------------
// overflow selections and values
// ----------------------------------------------------------------------
`define OVF_SEL_ALL       2'h0
`define OVF_SEL_B24       2'h1
`define OVF_SEL_B31       2'h2
`define OVF_ALL_ONES      32'hFFFF_FFFF
`define OVF_BIT24_CLR     32'hFEFF_FFFF
`define OVF_BIT31_CLR     32'h7FFF_FFFF

// ----------------------------------------------------------------------
// status line sensor-state codes
// ----------------------------------------------------------------------
`define ST_FREE_RUNNING   2'h0
`define ST_TRIGGERED      2'h1
`define ST_DEACTIVATED    2'h2

// ----------------------------------------------------------------------
// alignment register fields
// ----------------------------------------------------------------------
`define ALIGN_L_LO        0
`define ALIGN_M_LO        10
`define ALIGN_R_LO        20
`define ALIGN_NOOBJ_L     30
`define ALIGN_NOOBJ_M     31

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS     8
`define ENC_MAX_KHZ       300
`define ENC_FILT_NS       32
`define ENC_FILT_CYC      (`ENC_FILT_NS / `CLK_PERIOD_NS)
`define FLASH_HALF_MS     100
`define FLASH_HALF_CYC    ((`FLASH_HALF_MS * 1000000) / `CLK_PERIOD_NS)
`define CASC_PULSE_NS     800
`define CASC_PULSE_CYC    ((`CASC_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== src/encoder_counter_status_outputs.v
// encoder pulse counter with ready, cascade, led and status-line outputs
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/100ps
// Functional notes
// - ready output always equals green indicator
// - green steady after clean init, then measure
// - counter handles pulses up to 300 kHz
// - single or double evaluation modes
// - no four-edge counting offered
// - three selectable overflow values
// - all-ones overflow gives full 32-bit counter
// - reset defaults: two-channel, double, all-ones
// - setting reverses counting direction
// - single-channel mode counts channel A only
// - single-channel: B low up, high down
// - undriven B in single-channel counts up
// - yellow: link steady, traffic flashing, else off
// - status shows free, triggered or deactivated
// - status shows task index 0 to 15
// - left and middle alignment show zero without object
// - command mode accepted and indicated
// - deactivated: laser off, no data, no trigger
// - trigger input or a trigger command synchronises each measurement in triggered mode
`include "enc_map.vh"

module encoder_counter_status_outputs #(
	parameter FLASH_HALF = `FLASH_HALF_CYC,
	parameter MEAS_PERIOD = 1250,
	parameter MIN_DIST = 10'd20
) (
	// clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// classic wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output wire        wb_ack_o,
	output wire [31:0] wb_dat_o,
	// encoder connector channels
	input  wire        enc_a,
	input  wire        enc_b,
	// process pins
	input  wire        activation_in,
	input  wire        trigger_in,
	output wire        ready_out,
	output wire        cascade_out,
	// network link state from the host interface
	input  wire        link_up,
	input  wire        link_traffic,
	// indicators and status line
	output wire        led_green,
	output wire        led_yellow,
	output wire        laser_on,
	output wire        data_out_en,
	output wire        meas_start,
	output wire [1:0]  state_code,
	output wire [3:0]  task_disp,
	output wire        cmd_mode_ind,
	output wire [9:0]  disp_left,
	output wire [9:0]  disp_mid,
	output wire [9:0]  disp_right
);

	// ------------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------------
	// overflow value from selection; unused code falls back to all ones
	function [31:0] ovf_value;
		input [1:0] sel;
		begin
			case (sel)
				`OVF_SEL_B24: ovf_value = `OVF_BIT24_CLR;
				`OVF_SEL_B31: ovf_value = `OVF_BIT31_CLR;
				default:      ovf_value = `OVF_ALL_ONES;
			endcase
		end
	endfunction

	// blank a distance when no object or too close
	function [9:0] align_value;
		input [9:0] raw;
		input       no_obj;
		begin
			if (no_obj || (raw < MIN_DIST))
				align_value = 10'h000;
			else
				align_value = raw;
		end
	endfunction

	// byte-lane merge for wishbone writes
	function [31:0] lane_merge;
		input [31:0] old;
		input [31:0] new_val;
		input [3:0]  sel;
		integer i;
		begin
			lane_merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (sel[i])
					lane_merge[i*8 +: 8] = new_val[i*8 +: 8];
		end
	endfunction

	// ------------------------------------------------------------------
	// registers and wires
	// ------------------------------------------------------------------
	reg  [15:0] ctrl_ff;
	reg  [31:0] align_ff, cnt_ff, nxt_cnt, rdat_ff;
	reg  [31:0] run_cnt_ff, casc_cnt_ff, flash_cnt_ff;
	reg  [1:0]  sync_a_ff, sync_b_ff, sync_act_ff;
	reg  [1:0]  sync_trg_ff, sync_lnk_ff, sync_trf_ff;
	reg  [2:0]  stab_a_ff, stab_b_ff;
	reg         ack_ff, filt_a_ff, filt_b_ff, a_prev_ff;
	reg         trg_prev_ff, meas_ff, flash_ff, sw_trig_ff;
	wire        wb_req, wr_en, a_rise, a_fall, a_edge, cnt_up, raw_up;
	wire        active, ready, trig_evt, free_evt;
	wire [31:0] ovf;

	// ------------------------------------------------------------------
	// wishbone slave: one wait state, ack for one cycle
	// ------------------------------------------------------------------
	assign wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;
	assign wr_en  = wb_req & wb_we_i;

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ack_ff  <= 1'b0;
			rdat_ff <= 32'h0000_0000;
		end
		else
		begin
			ack_ff <= wb_req;
			case (wb_adr_i)
				`REG_CTRL:   rdat_ff <= {16'h0000, ctrl_ff};
				`REG_COUNT:  rdat_ff <= cnt_ff;
				`REG_STATUS: rdat_ff <= {16'h0000, cmd_mode_ind, 3'h0,
					task_disp, 1'b0, data_out_en, state_code,
					laser_on, led_yellow, led_green, ready_out};
				`REG_ALIGN:  rdat_ff <= align_ff;
				default:     rdat_ff <= 32'h0000_0000;  // unmapped reads zero
			endcase
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;

	// configuration registers; reset defaults are two-channel, double
	// evaluation, all-ones overflow; ctrl keeps the low half only
	wire [31:0] ctrl_wr = lane_merge({16'h0000, ctrl_ff}, wb_dat_i,
		wb_sel_i) & {16'h0000, `CTRL_WMASK};
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_ff    <= `CTRL_RESET;
			align_ff   <= 32'hC000_0000;
			sw_trig_ff <= 1'b0;
		end
		else
		begin
			sw_trig_ff <= wr_en && (wb_adr_i == `REG_TRIG) && wb_sel_i[0]
				&& wb_dat_i[0];
			if (wr_en && (wb_adr_i == `REG_CTRL))
				ctrl_ff <= ctrl_wr[15:0];
			if (wr_en && (wb_adr_i == `REG_ALIGN))
				align_ff <= lane_merge(align_ff, wb_dat_i, wb_sel_i);
		end
	end

	// ------------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------------
	// second stage is the only reader of each first stage
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync_a_ff   <= 2'h0;
			sync_b_ff   <= 2'h0;
			sync_act_ff <= 2'h0;
			sync_trg_ff <= 2'h0;
			sync_lnk_ff <= 2'h0;
			sync_trf_ff <= 2'h0;
		end
		else
		begin
			sync_a_ff   <= {sync_a_ff[0], enc_a};
			sync_b_ff   <= {sync_b_ff[0], enc_b};
			sync_act_ff <= {sync_act_ff[0], activation_in};
			sync_trg_ff <= {sync_trg_ff[0], trigger_in};
			sync_lnk_ff <= {sync_lnk_ff[0], link_up};
			sync_trf_ff <= {sync_trf_ff[0], link_traffic};
		end
	end

	// glitch filter: a new level must hold for the filter time; 32 ns
	// is far below the 1.67 us half period at the top pulse rate
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			filt_a_ff <= 1'b0;
			filt_b_ff <= 1'b0;
			stab_a_ff <= 3'h0;
			stab_b_ff <= 3'h0;
			a_prev_ff <= 1'b0;
		end
		else
		begin
			a_prev_ff <= filt_a_ff;  // edge detect one stage behind
			if (sync_a_ff[1] == filt_a_ff)
				stab_a_ff <= 3'h0;
			else if (stab_a_ff == `ENC_FILT_CYC - 1)
			begin
				filt_a_ff <= sync_a_ff[1];
				stab_a_ff <= 3'h0;
			end
			else
				stab_a_ff <= stab_a_ff + 3'h1;
			if (sync_b_ff[1] == filt_b_ff)
				stab_b_ff <= 3'h0;
			else if (stab_b_ff == `ENC_FILT_CYC - 1)
			begin
				filt_b_ff <= sync_b_ff[1];
				stab_b_ff <= 3'h0;
			end
			else
				stab_b_ff <= stab_b_ff + 3'h1;
		end
	end

	// ------------------------------------------------------------------
	// pulse counter
	// ------------------------------------------------------------------
	// only channel A edges count; B never clocks the counter, so no
	// four-edge mode exists
	assign a_rise = filt_a_ff & ~a_prev_ff;
	assign a_fall = ~filt_a_ff & a_prev_ff;
	// single evaluation counts rising edges, double counts both
	assign a_edge = ctrl_ff[`CTRL_SINGLE_EVAL] ? a_rise
		: (a_rise | a_fall);
	// single channel: B low counts up, high down; B is pulled low
	// outside so an open input counts up
	// two channel: A leading B counts up
	assign raw_up = ctrl_ff[`CTRL_SINGLE_CH] ? ~filt_b_ff
		: (a_rise ? ~filt_b_ff : filt_b_ff);
	assign cnt_up = raw_up ^ ctrl_ff[`CTRL_REVERSE];
	assign ovf    = ovf_value(ctrl_ff[`CTRL_OVF_HI:`CTRL_OVF_LO]);

	// next count with wrap at the overflow value
	always @*
	begin
		nxt_cnt = cnt_ff;
		if (a_edge)
		begin
			if (cnt_up)
				nxt_cnt = (cnt_ff >= ovf) ? 32'h0000_0000
					: cnt_ff + 32'h0000_0001;
			else
				nxt_cnt = (cnt_ff == 32'h0000_0000) ? ovf
					: cnt_ff - 32'h0000_0001;
		end
	end

	// a software load of the count wins over a pulse in the same cycle
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_ff <= 32'h0000_0000;
		else if (wr_en && (wb_adr_i == `REG_COUNT))
			cnt_ff <= lane_merge(cnt_ff, wb_dat_i, wb_sel_i);
		else
			cnt_ff <= nxt_cnt;
	end

	// ------------------------------------------------------------------
	// activation, trigger, measurement and cascade
	// ------------------------------------------------------------------
	assign active   = sync_act_ff[1];
	assign ready    = ctrl_ff[`CTRL_INIT_DONE] & ~ctrl_ff[`CTRL_INIT_ERR];
	// triggers come from the pin or a command, only while active
	assign trig_evt = active & ready & ctrl_ff[`CTRL_TRIG_MODE]
		& ((sync_trg_ff[1] & ~trg_prev_ff) | sw_trig_ff);
	assign free_evt = active & ready & ~ctrl_ff[`CTRL_TRIG_MODE]
		& (run_cnt_ff == MEAS_PERIOD - 1);

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			trg_prev_ff <= 1'b0;
			meas_ff     <= 1'b0;
			run_cnt_ff  <= 32'h0000_0000;
			casc_cnt_ff <= 32'h0000_0000;
		end
		else
		begin
			trg_prev_ff <= sync_trg_ff[1];
			meas_ff     <= trig_evt | free_evt;
			if (free_evt || !active || ctrl_ff[`CTRL_TRIG_MODE])
				run_cnt_ff <= 32'h0000_0000;
			else
				run_cnt_ff <= run_cnt_ff + 32'h0000_0001;
			// each measurement start hands a pulse down the chain
			if (trig_evt || free_evt)
				casc_cnt_ff <= `CASC_PULSE_CYC;
			else if (casc_cnt_ff != 32'h0000_0000)
				casc_cnt_ff <= casc_cnt_ff - 32'h0000_0001;
		end
	end

	assign meas_start  = meas_ff;
	assign cascade_out = (casc_cnt_ff != 32'h0000_0000);
	assign laser_on    = active;
	assign data_out_en = active & ready;

	// ------------------------------------------------------------------
	// yellow indicator flash timer
	// ------------------------------------------------------------------
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flash_cnt_ff <= 32'h0000_0000;
			flash_ff     <= 1'b0;
		end
		else if (flash_cnt_ff == FLASH_HALF - 1)
		begin
			flash_cnt_ff <= 32'h0000_0000;
			flash_ff     <= ~flash_ff;
		end
		else
			flash_cnt_ff <= flash_cnt_ff + 32'h0000_0001;
	end

	// ------------------------------------------------------------------
	// indicators and status line
	// ------------------------------------------------------------------
	assign led_green  = ready;
	assign ready_out  = led_green;
	assign led_yellow = sync_lnk_ff[1]
		& (sync_trf_ff[1] ? flash_ff : 1'b1);
	assign state_code = !active ? `ST_DEACTIVATED
		: (ctrl_ff[`CTRL_TRIG_MODE] ? `ST_TRIGGERED
		: `ST_FREE_RUNNING);
	// four bits hold exactly tasks 0 to 15
	assign task_disp  = ctrl_ff[`CTRL_TASK_HI:`CTRL_TASK_LO];
	assign cmd_mode_ind = ctrl_ff[`CTRL_CMD_MODE];
	assign disp_left  = align_value(align_ff[`ALIGN_L_LO +: 10],
		align_ff[`ALIGN_NOOBJ_L]);
	assign disp_mid   = align_value(align_ff[`ALIGN_M_LO +: 10],
		align_ff[`ALIGN_NOOBJ_M]);
	assign disp_right = align_value(align_ff[`ALIGN_R_LO +: 10],
		1'b0);

endmodule

// ===== sim/enc_status_assertions.sv
// assertion checker for the encoder counter status outputs
`timescale 1ns/100ps
`include "enc_map.vh"
module enc_status_checker #(
	parameter MIN_DIST = 10'd20
) (
	// clock and reset
	input wire       clk,
	input wire       rst_n,
	// bus handshake
	input wire       wb_cyc_i,
	input wire       wb_stb_i,
	input wire       wb_ack_o,
	// link state
	input wire       link_up,
	input wire       link_traffic,
	// pins and indicators
	input wire       ready_out,
	input wire       cascade_out,
	input wire       led_green,
	input wire       led_yellow,
	input wire       laser_on,
	input wire       data_out_en,
	input wire       meas_start,
	input wire [1:0] state_code,
	input wire [9:0] disp_left,
	input wire [9:0] disp_mid,
	input wire [9:0] disp_right
);
	// ------
	// one clock domain, reset disables all
	// ------
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_ready_is_green: assert property (ready_out == led_green)
		else $error("ready output differs from green led");
	a_data_when_ready: assert property (data_out_en |-> led_green)
		else $error("data enabled while not ready");
	a_dark_state: assert property (!laser_on |->
		!data_out_en && state_code == `ST_DEACTIVATED)
		else $error("deactivated sensor shows wrong state");
	a_state_legal: assert property (state_code != 2'h3)
		else $error("undefined state code");
	a_dark_no_meas: assert property (!laser_on [*6] |-> !meas_start)
		else $error("measurement started while deactivated");
	a_casc_follows: assert property (meas_start |=> cascade_out [*8])
		else $error("cascade output missing after start");
	a_yellow_off: assert property (!link_up [*4] |-> !led_yellow)
		else $error("yellow lit without link");
	a_yellow_steady: assert property
		((link_up && !link_traffic) [*4] |-> led_yellow)
		else $error("yellow not steady on idle link");
	a_disp_floor: assert property
		((disp_left == 0 || disp_left >= MIN_DIST) &&
		(disp_mid == 0 || disp_mid >= MIN_DIST) &&
		(disp_right == 0 || disp_right >= MIN_DIST))
		else $error("alignment value below minimum shown");
	a_ack_single: assert property
		(wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer not a single pulse");

	// main scenarios reached
	c_meas: cover property (meas_start);
	c_casc: cover property ($rose(cascade_out));
	c_flash: cover property (link_up && link_traffic ##1 $fell(led_yellow));
endmodule

bind encoder_counter_status_outputs enc_status_checker #(
	.MIN_DIST(MIN_DIST)
) u_checker (
	.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .link_up(link_up), .link_traffic(link_traffic),
	.ready_out(ready_out), .cascade_out(cascade_out),
	.led_green(led_green), .led_yellow(led_yellow), .laser_on(laser_on),
	.data_out_en(data_out_en), .meas_start(meas_start),
	.state_code(state_code), .disp_left(disp_left), .disp_mid(disp_mid),
	.disp_right(disp_right)
);

// ===== sim/encoder_model.sv
// behavioural incremental encoder driving channels a and b
`timescale 1ns/100ps
module encoder_model (
	// pacing clock
	input  wire  clk,
	// encoder channels
	output logic a,
	output logic b
);
	// 105 cycles a phase keeps the period above 3.33 us
	int hold = 105;

	// channels rest low; a released b sits at its pull-down
	initial
	begin
		a = 1'b0;
		b = 1'b0;
	end

	// one phase: wait, then move both channels
	task automatic ph(input logic na, input logic nb);
		repeat (hold) @(posedge clk);
		a <= na;
		b <= nb;
	endtask

	// quadrature periods; b lags a when moving up
	task automatic quad(input bit up, input int n);
		for (int i = 0; i < n; i++)
		begin
			ph(up, !up);
			ph(1'b1, 1'b1);
			ph(!up, up);
			ph(1'b0, 1'b0);
		end
	endtask

	// single channel: b set as direction level first, then a pulses;
	// each level lasts two phases so the rate stays under the limit
	task automatic pulse(input logic dir, input int n);
		ph(1'b0, dir);
		for (int i = 0; i < n; i++)
		begin
			repeat (2) ph(1'b1, dir);
			repeat (2) ph(1'b0, dir);
		end
	endtask

	// 16 ns spike on a, too short to be a real edge
	task automatic glitch;
		repeat (hold) @(posedge clk);
		a <= ~a;
		repeat (2) @(posedge clk);
		a <= ~a;
	endtask
endmodule

// ===== sim/encoder_counter_status_outputs_tb.sv
// self-checking bench for the encoder counter status outputs
`timescale 1ns/100ps
`include "enc_map.vh"
module encoder_counter_status_outputs_tb;
	// bus master and pin drivers
	logic        clk, rst_n, cyc, stb, we, act, trig, lnk, trf;
	logic [7:0]  adr;
	logic [31:0] wdat, rdat;
	// design outputs
	wire         ack, ready, casc, green, yellow, laser, dout, meas, cmd;
	wire         ea, eb;
	wire [31:0]  dat_o;
	wire [1:0]   st;
	wire [3:0]   task_d;
	wire [9:0]   dl, dm, dr;
	int          n_errors = 0;
	int          check_count = 0;

	// short flash and measure periods keep the run brief
	encoder_counter_status_outputs #(
		.FLASH_HALF(8),
		.MEAS_PERIOD(20),
		.MIN_DIST(10'h014)
	) dut (
		.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
		.wb_ack_o(ack), .wb_dat_o(dat_o), .enc_a(ea), .enc_b(eb),
		.activation_in(act), .trigger_in(trig), .ready_out(ready),
		.cascade_out(casc), .link_up(lnk), .link_traffic(trf),
		.led_green(green), .led_yellow(yellow), .laser_on(laser),
		.data_out_en(dout), .meas_start(meas), .state_code(st),
		.task_disp(task_d), .cmd_mode_ind(cmd), .disp_left(dl),
		.disp_mid(dm), .disp_right(dr)
	);
	encoder_model enc (.clk(clk), .a(ea), .b(eb));

	// 125 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ------
	// shared tasks
	// ------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// classic cycle, entered just after a rising edge
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		int t;
		t = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		adr <= a;
		we <= w;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1 && t < 40)
		begin
			@(posedge clk);
			t++;
		end
		rdat = dat_o;
		if (t == 40)
		begin
			n_errors++;
			$display("ERROR at %0t: no bus answer", $time);
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	// count settles 7 cycles after the last edge
	task automatic cnt(input logic [31:0] exp);
		repeat (12) @(posedge clk);
		bus(`REG_COUNT, 1'b0, 32'h0);
		check(rdat, exp);
	endtask

	task automatic wait_meas(input int n, output logic [31:0] got);
		got = 32'h0;
		repeat (n)
		begin
			@(posedge clk);
			if (meas === 1'b1)
				got = 32'h1;
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ------
	// scenarios
	// ------
	task automatic t_reset;
		bus(`REG_CTRL, 1'b0, 32'h0);
		check(rdat, 32'h0);
		check(32'(st), 32'(`ST_DEACTIVATED));
		check({31'h0, laser}, 32'h0);
		bus(8'h20, 1'b1, 32'hFFFF_FFFF);
		bus(8'h20, 1'b0, 32'h0);
		check(rdat, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_ready;
		act <= 1'b1;
		bus(`REG_CTRL, 1'b1, 32'h0060);
		check({31'h0, ready}, 32'h0);
		bus(`REG_CTRL, 1'b1, 32'h0020);
		repeat (4) @(posedge clk);
		check({31'h0, ready}, 32'h1);
		check({31'h0, dout}, 32'h1);
		check({31'h0, green}, 32'h1);
		$display("test ready done");
	endtask

	task automatic t_align;
		bus(`REG_ALIGN, 1'b1, {2'b00, 10'h12C, 10'h005, 10'h064});
		check({2'b00, dl, dm, dr}, {2'b00, 10'h064, 10'h000, 10'h12C});
		bus(`REG_ALIGN, 1'b1, {2'b01, 10'h12C, 10'h005, 10'h064});
		check({2'b00, dl, dm, dr}, {2'b00, 10'h000, 10'h000, 10'h12C});
		$display("test align done");
	endtask

	task automatic t_quad;
		bus(`REG_COUNT, 1'b1, 32'h0);
		enc.quad(1'b1, 3);
		cnt(32'h6);
		enc.quad(1'b0, 1);
		cnt(32'h4);
		bus(`REG_CTRL, 1'b1, 32'h0022);
		enc.quad(1'b1, 2);
		cnt(32'h6);
		bus(`REG_CTRL, 1'b1, 32'h0032);
		enc.quad(1'b1, 1);
		cnt(32'h5);
		enc.glitch();
		cnt(32'h5);
		$display("test quadrature done");
	endtask

	task automatic t_wrap;
		logic [31:0] ovf [3];
		ovf = '{`OVF_ALL_ONES, `OVF_BIT24_CLR, `OVF_BIT31_CLR};
		for (int s = 0; s < 3; s++)
		begin
			bus(`REG_CTRL, 1'b1, 32'h0023 | (s << 2));
			bus(`REG_COUNT, 1'b1, 32'h0);
			enc.pulse(1'b1, 1);
			cnt(ovf[s]);
			enc.pulse(1'b0, 1);
			cnt(32'h0);
		end
		bus(`REG_CTRL, 1'b1, 32'h0021);
		enc.pulse(1'b1, 1);
		cnt(32'hFFFF_FFFE);
		enc.pulse(1'b0, 2);
		cnt(32'h2);
		$display("test wrap done");
	endtask

	task automatic t_status;
		logic [31:0] g;
		bus(`REG_CTRL, 1'b1, 32'hF1A0);
		check(32'(task_d), 32'hF);
		check({31'h0, cmd}, 32'h1);
		check(32'(st), 32'(`ST_TRIGGERED));
		trig <= 1'b1;
		wait_meas(40, g);
		check(g, 32'h1);
		check({31'h0, casc}, 32'h1);
		trig <= 1'b0;
		// the start pulse stands inside the bus cycle, so watch alongside
		fork
			bus(`REG_TRIG, 1'b1, 32'h1);
			wait_meas(40, g);
		join
		check(g, 32'h1);
		act <= 1'b0;
		repeat (8) @(posedge clk);
		check(32'(st), 32'(`ST_DEACTIVATED));
		trig <= 1'b1;
		wait_meas(40, g);
		check(g, 32'h0);
		trig <= 1'b0;
		act <= 1'b1;
		bus(`REG_CTRL, 1'b1, 32'h0020);
		repeat (8) @(posedge clk);
		check(32'(st), 32'(`ST_FREE_RUNNING));
		check({31'h0, cmd}, 32'h0);
		wait_meas(60, g);
		check(g, 32'h1);
		$display("test status done");
	endtask

	task automatic t_link;
		int flips;
		logic p;
		lnk <= 1'b1;
		repeat (8) @(posedge clk);
		check({31'h0, yellow}, 32'h1);
		trf <= 1'b1;
		flips = 0;
		p = yellow;
		repeat (40)
		begin
			@(posedge clk);
			if (yellow !== p)
				flips++;
			p = yellow;
		end
		check({31'h0, flips >= 3}, 32'h1);
		lnk <= 1'b0;
		trf <= 1'b0;
		repeat (8) @(posedge clk);
		check({31'h0, yellow}, 32'h0);
		$display("test link done");
	endtask

	// main sequence after a six cycle reset
	initial
	begin
		rst_n = 1'b0;
		{cyc, stb, we, act, trig, lnk, trf} = 7'h00;
		adr = 8'h00;
		wdat = 32'h0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_ready();
		t_align();
		t_quad();
		t_wrap();
		t_status();
		t_link();
		print_verdict();
	end

	// watchdog well past the expected 8200 cycles
	initial
	begin
		repeat (60000) @(posedge clk);
		n_errors++;
		$display("ERROR at %0t: watchdog expired", $time);
		print_verdict();
	end
endmodule
